// ### rtl/pgtm_params.svh
// constants for the power-good tree mask register bank
`ifndef PGTM_PARAMS_SVH
`define PGTM_PARAMS_SVH

// register offsets
`define PGTM_OFS_OUT1_RAIL      8'hA4
`define PGTM_OFS_OUT1_PIN_RAIL  8'hA5
`define PGTM_OFS_OUT4_RAIL      8'hA6

// rail-mask field positions (both rail-mask registers)
`define PGTM_BIT_LDO2           7
`define PGTM_BIT_SWITCH1        6
`define PGTM_BIT_STEPDOWN_HI    5
`define PGTM_BIT_STEPDOWN_LO    0

// pin-and-rail mask field positions
`define PGTM_BIT_PIN_FIVE       7
`define PGTM_BIT_PIN_FOUR       6
`define PGTM_BIT_PIN_TWO        5
`define PGTM_BIT_PIN_ONE        4
`define PGTM_BIT_TERM           3
`define PGTM_BIT_SHARED         2
`define PGTM_BIT_BANKB_SW1      1
`define PGTM_BIT_LDO3           0

// factory variant codes; variant 3 routes bank b switch 2 into the shared bit
`define PGTM_VARIANT_BANKB_SW2  2'h3

// factory defaults per variant 0..3
`define PGTM_RST_OUT1_RAIL_V0   8'hFD
`define PGTM_RST_OUT1_RAIL_V1   8'h5C
`define PGTM_RST_OUT1_RAIL_V2   8'hFE
`define PGTM_RST_OUT1_RAIL_V3   8'hFC
`define PGTM_RST_OUT1_PIN_V0    8'hFF
`define PGTM_RST_OUT1_PIN_V1    8'hEB
`define PGTM_RST_OUT1_PIN_V2    8'hFF
`define PGTM_RST_OUT1_PIN_V3    8'hEF
`define PGTM_RST_OUT4_RAIL_V0   8'hF7
`define PGTM_RST_OUT4_RAIL_V1   8'hBF
`define PGTM_RST_OUT4_RAIL_V2   8'hF7
`define PGTM_RST_OUT4_RAIL_V3   8'hFF

// unmapped reads return this
`define PGTM_RDATA_UNMAPPED     8'h00

`endif

// ### rtl/pgtm_pkg.sv
// types shared by the power-good tree mask bank
package pgtm_pkg;

  // rail good indications, 1 = good
  typedef struct packed {
    logic       second_adjustable_ldo;
    logic       first_load_switch;
    logic [5:0] stepdown_rail;        // [5] = rail six ... [0] = rail one
    logic       first_adjustable_ldo;
    logic       third_adjustable_ldo;
    logic       bank_b_first_switch;
    logic       bank_b_second_switch;
    logic       memory_termination_ldo;
  } pgtm_rail_good_t;

  // control input pin states
  typedef struct packed {
    logic control_input_five;
    logic control_input_four;
    logic control_input_two;
    logic control_input_one;
  } pgtm_ctl_pins_t;

  // register access port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pgtm_reg_req_t;

endpackage

// ### rtl/pgtm_tree.sv
// one power-good tree: and of every source not masked, registered
`timescale 1ns/1ns
module pgtm_tree #(
  parameter int N = 8
) (
  // clock, reset and enable
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // sources and masks
  input  wire logic [N-1:0] good_i,
  input  wire logic [N-1:0] mask_i,
  // result
  output logic              good_o
);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      good_o <= 1'b0;
    else if (ce_i)
      good_o <= &(good_i | mask_i);  // all masked reads as good
  end

endmodule // pgtm_tree

// ### rtl/pgtm_bank.sv
// power-good tree mask registers for general outputs one and four
`timescale 1ns/1ns
`include "pgtm_params.svh"
module pgtm_bank #(
  parameter logic [1:0] VARIANT = 2'h0
) (
  // clock, reset, enable
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  // register access
  input  wire pgtm_pkg::pgtm_reg_req_t  req_i,
  output logic [7:0]                    rdata_o,
  output logic                          rvalid_o,
  // sources
  input  wire pgtm_pkg::pgtm_rail_good_t rail_i,
  input  wire pgtm_pkg::pgtm_ctl_pins_t  ctl_i,
  // tree results
  output logic                          general_output_one_o,
  output logic                          general_output_four_o
);

  logic [7:0]  out1_rail_q;
  logic [7:0]  out1_pin_q;
  logic [7:0]  out4_rail_q;
  logic [7:0]  rail_src;
  logic [7:0]  pin_src;
  logic        shared_src;

  // factory default of one register for the build variant
  function automatic logic [7:0] pick(input logic [7:0] v0, input logic [7:0] v1,
                                       input logic [7:0] v2, input logic [7:0] v3);
    unique case (VARIANT)
      2'h0: pick = v0;
      2'h1: pick = v1;
      2'h2: pick = v2;
      2'h3: pick = v3;
    endcase
  endfunction

  localparam logic [7:0] RST_OUT1_RAIL = pick(`PGTM_RST_OUT1_RAIL_V0, `PGTM_RST_OUT1_RAIL_V1,
                                              `PGTM_RST_OUT1_RAIL_V2, `PGTM_RST_OUT1_RAIL_V3);
  localparam logic [7:0] RST_OUT1_PIN  = pick(`PGTM_RST_OUT1_PIN_V0, `PGTM_RST_OUT1_PIN_V1,
                                              `PGTM_RST_OUT1_PIN_V2, `PGTM_RST_OUT1_PIN_V3);
  localparam logic [7:0] RST_OUT4_RAIL = pick(`PGTM_RST_OUT4_RAIL_V0, `PGTM_RST_OUT4_RAIL_V1,
                                              `PGTM_RST_OUT4_RAIL_V2, `PGTM_RST_OUT4_RAIL_V3);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      out1_rail_q <= RST_OUT1_RAIL;
    else if (ce_i && req_i.wr && req_i.addr == `PGTM_OFS_OUT1_RAIL)
      out1_rail_q <= req_i.wdata;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      out1_pin_q <= RST_OUT1_PIN;
    else if (ce_i && req_i.wr && req_i.addr == `PGTM_OFS_OUT1_PIN_RAIL)
      out1_pin_q <= req_i.wdata;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      out4_rail_q <= RST_OUT4_RAIL;
    else if (ce_i && req_i.wr && req_i.addr == `PGTM_OFS_OUT4_RAIL)
      out4_rail_q <= req_i.wdata;
  end

  // read port: data one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_o  <= `PGTM_RDATA_UNMAPPED;
      rvalid_o <= 1'b0;
    end
    else if (ce_i)
    begin
      rvalid_o <= req_i.rd;
      if (req_i.rd)
      begin
        unique case (req_i.addr)
          `PGTM_OFS_OUT1_RAIL:     rdata_o <= out1_rail_q;
          `PGTM_OFS_OUT1_PIN_RAIL: rdata_o <= out1_pin_q;
          `PGTM_OFS_OUT4_RAIL:     rdata_o <= out4_rail_q;
          default:                 rdata_o <= `PGTM_RDATA_UNMAPPED;
        endcase
      end
    end
  end

  // source vectors in register bit order
  always_comb
  begin
    rail_src = '0;
    rail_src[`PGTM_BIT_LDO2]    = rail_i.second_adjustable_ldo;
    rail_src[`PGTM_BIT_SWITCH1] = rail_i.first_load_switch;
    rail_src[`PGTM_BIT_STEPDOWN_HI:`PGTM_BIT_STEPDOWN_LO] = rail_i.stepdown_rail;
  end

  // variant fixed at build time, so the shared bit is a static mux
  assign shared_src = (VARIANT == `PGTM_VARIANT_BANKB_SW2) ? rail_i.bank_b_second_switch
                                                            : rail_i.first_adjustable_ldo;

  always_comb
  begin
    pin_src = '0;
    pin_src[`PGTM_BIT_PIN_FIVE]  = ctl_i.control_input_five;
    pin_src[`PGTM_BIT_PIN_FOUR]  = ctl_i.control_input_four;
    pin_src[`PGTM_BIT_PIN_TWO]   = ctl_i.control_input_two;
    pin_src[`PGTM_BIT_PIN_ONE]   = ctl_i.control_input_one;
    pin_src[`PGTM_BIT_TERM]      = rail_i.memory_termination_ldo;
    pin_src[`PGTM_BIT_SHARED]    = shared_src;
    pin_src[`PGTM_BIT_BANKB_SW1] = rail_i.bank_b_first_switch;
    pin_src[`PGTM_BIT_LDO3]      = rail_i.third_adjustable_ldo;
  end

  // output one sees both registers
  pgtm_tree #(.N(16)) u_tree_one (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .good_i ({pin_src, rail_src}),
    .mask_i ({out1_pin_q, out1_rail_q}),
    .good_o (general_output_one_o)
  );

  // output four: only its rail mask lives here; its second mask belongs elsewhere
  pgtm_tree #(.N(8)) u_tree_four (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .good_i (rail_src),
    .mask_i (out4_rail_q),
    .good_o (general_output_four_o)
  );

endmodule // pgtm_bank

// ### verification/pgtm_bank_sva.sv
// assertions on the mask bank ports
`timescale 1ns/1ns
module pgtm_bank_chk (
  // watched ports
  input wire logic                      clk_i,
  input wire logic                      rst_i,
  input wire logic                      ce_i,
  input wire pgtm_pkg::pgtm_reg_req_t   req_i,
  input wire logic [7:0]                rdata_o,
  input wire logic                      rvalid_o,
  input wire pgtm_pkg::pgtm_rail_good_t rail_i,
  input wire pgtm_pkg::pgtm_ctl_pins_t  ctl_i,
  input wire logic                      general_output_one_o,
  input wire logic                      general_output_four_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_RVALID: assert property (ce_i |=> rvalid_o == $past(req_i.rd))
    else $error("read valid wrong");
  AST_HOLD: assert property (ce_i && !req_i.rd |=> $stable(rdata_o))
    else $error("read data moved");
  AST_WRRD: assert property (ce_i && req_i.wr ##1 ce_i && req_i.rd && !req_i.wr &&
    $stable(req_i.addr) && req_i.addr inside {[8'hA4:8'hA6]} |=> rdata_o == $past(req_i.wdata, 2))
    else $error("read-back wrong");
  AST_UNMAP: assert property (ce_i && req_i.rd && !(req_i.addr inside {[8'hA4:8'hA6]}) |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_FREEZE: assert property (!ce_i |=> $stable({general_output_one_o, general_output_four_o, rvalid_o}))
    else $error("moved with enable low");
  AST_GOOD1: assert property (ce_i && &rail_i && &ctl_i |=> general_output_one_o)
    else $error("output one low");
  AST_GOOD4: assert property (ce_i && &rail_i |=> general_output_four_o)
    else $error("output four low");
  // output four must not follow the control pins, only rails and its own mask
  AST_PINFREE4: assert property (ce_i && $past(ce_i) && !$past(rst_i) && !$past(req_i.wr) && $stable(rail_i)
    |=> $stable(general_output_four_o))
    else $error("output four moved");
endmodule // pgtm_bank_chk

bind pgtm_bank pgtm_bank_chk u_chk (.clk_i, .rst_i, .ce_i, .req_i, .rdata_o, .rvalid_o, .rail_i, .ctl_i,
  .general_output_one_o, .general_output_four_o);

// ### verification/pgtm_soc.sv
// controller model that drives the control pins
`timescale 1ns/1ns
module pgtm_soc (
  // pins
  input  wire pgtm_pkg::pgtm_ctl_pins_t cmd_i,
  output pgtm_pkg::pgtm_ctl_pins_t      ctl_o
);
  assign ctl_o = cmd_i;
endmodule // pgtm_soc

// ### verification/power_good_tree_masks_bench.sv
// random and corner bench for the mask bank
`timescale 1ns/1ns
`include "pgtm_params.svh"
module power_good_tree_masks_bench;
  logic                      clk = 1'b0, rst = 1'b1, ce = 1'b1, rv, o1, o4, rv0, p1, p4;
  logic [3:0]                e = 4'h0;
  logic [7:0]                rd, rd0, m [3];
  logic [31:0]               s = 32'h0001590B;
  int                        failures = 0, compares = 0, cyc = 0;
  pgtm_pkg::pgtm_reg_req_t   req = '0;
  pgtm_pkg::pgtm_rail_good_t rail = '1;
  pgtm_pkg::pgtm_ctl_pins_t  cmd = '1, ctl;
  pgtm_bank #(.VARIANT(2'h3)) uut (.clk_i(clk), .rst_i(rst), .ce_i(ce), .req_i(req), .rdata_o(rd), .rvalid_o(rv),
    .rail_i(rail), .ctl_i(ctl), .general_output_one_o(o1), .general_output_four_o(o4));
  // second build variant: other factory defaults, first ldo on the shared bit
  pgtm_bank #(.VARIANT(2'h0)) uut_v0 (.clk_i(clk), .rst_i(rst), .ce_i(ce), .req_i(req), .rdata_o(rd0),
    .rvalid_o(rv0), .rail_i(rail), .ctl_i(ctl), .general_output_one_o(p1), .general_output_four_o(p4));
  pgtm_soc soc (.cmd_i(cmd), .ctl_o(ctl));
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // the shared bit follows bank b switch 2 on variant 3, the first ldo on the others
  function automatic logic [1:0] tree(input logic bsw);
    logic [7:0] sa;
    logic       sh;
    sa = {rail.second_adjustable_ldo, rail.first_load_switch, rail.stepdown_rail};
    sh = bsw ? rail.bank_b_second_switch : rail.first_adjustable_ldo;
    return {&(sa | m[2]), &(sa | m[0]) & &({cmd, rail.memory_termination_ldo, sh,
      rail.bank_b_first_switch, rail.third_adjustable_ldo} | m[1])};
  endfunction
  task automatic chk(string n, logic [7:0] x, logic [7:0] v);
    compares++;
    if (v !== x)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, x, v);
    end
  endtask
  // optional write, then a read of the same place on the very next edge
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d, logic [7:0] x, logic [7:0] x0);
    @(negedge clk) req = '{w, 1'b0, a, d};
    @(negedge clk) req = '{1'b0, 1'b1, a, d};
    @(negedge clk) req.rd = 1'b0;
    chk("read valid", 8'h01, {7'h0, rv});
    chk("read data", x, rd);
    chk("read valid v0", 8'h01, {7'h0, rv0});
    chk("read data v0", x0, rd0);
  endtask
  task automatic close_out(int late);
    failures += late;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always #5 clk = ~clk;
  always @(posedge clk)
    if (++cyc == 5000) close_out(1);
  initial
  begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    acc(1'b0, `PGTM_OFS_OUT1_RAIL, 8'h00, `PGTM_RST_OUT1_RAIL_V3, `PGTM_RST_OUT1_RAIL_V0);
    acc(1'b0, `PGTM_OFS_OUT1_PIN_RAIL, 8'h00, `PGTM_RST_OUT1_PIN_V3, `PGTM_RST_OUT1_PIN_V0);
    acc(1'b0, `PGTM_OFS_OUT4_RAIL, 8'h00, `PGTM_RST_OUT4_RAIL_V3, `PGTM_RST_OUT4_RAIL_V0);
    acc(1'b1, 8'hA7, 8'h5A, `PGTM_RDATA_UNMAPPED, `PGTM_RDATA_UNMAPPED);
    $display("defaults and unmapped done");
    for (int r = 0; r < 16; r++)
    begin
      for (int k = 0; k < 3; k++)
      begin
        m[k] = r == 0 ? 8'hFF : r == 1 ? 8'h00 : 8'(rnd());
        acc(1'b1, 8'hA4 + 8'(k), m[k], m[k], m[k]);
      end
      for (int j = 0; j < 24; j++)
      begin
        @(negedge clk);
        if (j > 0) chk("trees", {4'h0, e}, {4'h0, o4, o1, p4, p1});
        {rail, cmd} = 17'(~(rnd() & rnd() & rnd()));
        e = {tree(1'b1), tree(1'b0)};
      end
    end
    $display("tree sweep done");
    @(negedge clk) ce = 1'b0;
    rail = '0;
    // a write while frozen must not land
    req = '{1'b1, 1'b1, `PGTM_OFS_OUT1_RAIL, ~m[0]};
    repeat (3) @(negedge clk);
    chk("frozen trees", {4'h0, e}, {4'h0, o4, o1, p4, p1});
    req = '0;
    ce = 1'b1;
    acc(1'b0, `PGTM_OFS_OUT1_RAIL, 8'h00, m[0], m[0]);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    acc(1'b0, `PGTM_OFS_OUT1_PIN_RAIL, 8'h00, `PGTM_RST_OUT1_PIN_V3, `PGTM_RST_OUT1_PIN_V0);
    $display("freeze and reset done");
    close_out(0);
  end
endmodule // power_good_tree_masks_bench
